// ==== design/field_access_regs.sv ====
// Register file holding one field of every access type, device end of the bus
//
// Summary of operation
// - Read/write field holds, returns, drives value.
// - Virtual read/write passes through to hardware storage.
// - Read field registers hardware value; writes ignored.
// - Virtual read returns hardware value; writes ignored.
// - Write field strobes hardware; reads return constant.
// - Virtual write forwards writes to hardware storage.
// - Hardware and software both update; hardware wins.
// - Latch high level, clear on read.
// - Latch low level, clear on read.
// - Latch high level, ones written clear bits.
// - Latch low level, ones written clear bits.
// - Rising edge sets, clear on read.
// - Falling edge sets, clear on read.
// - High-to-low edge sets, ones mask clears.
// - Low-to-high edge sets, ones mask clears.
// - Enable field gates interrupt sources onto output.
// - Value captured first clock after reset release.
// - Self-clearing write gives one-cycle strobe.
// - Self-clearing field holds until hardware clears.
`default_nettype none
`include "field_access_defs.svh"

module field_access_regs
  import field_access_pkg::*;
#(
  parameter int DATA_W = `FA_DATA_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Register bus
  reg_bus_if.device              bus,
  // Plain and virtual read/write fields
  output logic      [DATA_W-1:0] ctrl_out,
  input  wire logic [DATA_W-1:0] vrw_rdata,
  output logic                   vrw_wr,
  output logic      [DATA_W-1:0] vrw_wdata,
  // Read fields
  input  wire logic [DATA_W-1:0] status_in,
  input  wire logic [DATA_W-1:0] vr_data,
  // Write fields
  output logic                   act_wr,
  output logic      [DATA_W-1:0] act_data,
  output logic                   vw_wr,
  output logic      [DATA_W-1:0] vw_wdata,
  // Shared field
  input  wire logic              rwh_hw_load,
  input  wire logic [DATA_W-1:0] rwh_hw_data,
  output logic      [DATA_W-1:0] rwh_out,
  // Latch and edge sources
  input  wire logic [DATA_W-1:0] lhsc_in,
  input  wire logic [DATA_W-1:0] llsc_in,
  input  wire logic [DATA_W-1:0] lhmk_in,
  input  wire logic [DATA_W-1:0] llmk_in,
  input  wire logic [DATA_W-1:0] ihsc_in,
  input  wire logic [DATA_W-1:0] ilsc_in,
  input  wire logic [DATA_W-1:0] ihmk_in,
  input  wire logic [DATA_W-1:0] ilmk_in,
  output logic                   irq,
  // Latch on reset field
  input  wire logic [DATA_W-1:0] lor_in,
  output logic      [DATA_W-1:0] lor_out,
  // Self-clearing field
  input  wire logic [DATA_W-1:0] rwsc_clr,
  output logic      [DATA_W-1:0] rwsc_strobe,
  output logic      [DATA_W-1:0] rwsc_out
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [DATA_W-1:0] ctrl_reg, status_reg, rwh_reg, ien_reg, lor_reg, rwsc_reg;
  logic [DATA_W-1:0] vrw_wdata_reg, act_data_reg, vw_wdata_reg, rwsc_strobe_reg;
  logic              vrw_wr_reg, act_wr_reg, vw_wr_reg, irq_reg, lor_done_reg;
  logic [DATA_W-1:0] lhsc_reg, llsc_reg, lhmk_reg, llmk_reg;
  logic [DATA_W-1:0] ihsc_reg, ilsc_reg, ihmk_reg, ilmk_reg;
  logic [DATA_W-1:0] ihsc_prev_reg, ilsc_prev_reg, ihmk_prev_reg, ilmk_prev_reg;
  logic [DATA_W-1:0] rdata_reg, rd_mux;
  logic              rvalid_reg;

  // ****************************************************************
  // Access decode
  // ****************************************************************
  function automatic logic wr_hit(input logic [`FA_ADDR_W-1:0] ofs);
    wr_hit = bus.wr_en && (bus.addr == ofs);
  endfunction : wr_hit

  function automatic logic rd_hit(input logic [`FA_ADDR_W-1:0] ofs);
    rd_hit = bus.rd_en && (bus.addr == ofs);
  endfunction : rd_hit

  // Ones written to a mask-clearing field, zero when it is not addressed
  function automatic logic [DATA_W-1:0] wr_mask(input logic [`FA_ADDR_W-1:0] ofs);
    wr_mask = wr_hit(ofs) ? bus.wdata : '0;
  endfunction : wr_mask

  function automatic logic [DATA_W-1:0] rd_mask(input logic [`FA_ADDR_W-1:0] ofs);
    rd_mask = {DATA_W{rd_hit(ofs)}};
  endfunction : rd_mask

  // ****************************************************************
  // Basic access types
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= `FA_RST_VAL;
    end else if (wr_hit(`FA_OFS_RW)) begin
      ctrl_reg <= bus.wdata;
    end
  end

  // Storage of the virtual fields lives in the attached hardware
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vrw_wr_reg    <= 1'b0;
      vrw_wdata_reg <= `FA_RST_VAL;
      act_wr_reg    <= 1'b0;
      act_data_reg  <= `FA_RST_VAL;
      vw_wr_reg     <= 1'b0;
      vw_wdata_reg  <= `FA_RST_VAL;
    end else begin
      vrw_wr_reg <= wr_hit(`FA_OFS_RWV);
      act_wr_reg <= wr_hit(`FA_OFS_W);
      vw_wr_reg  <= wr_hit(`FA_OFS_WV);
      if (wr_hit(`FA_OFS_RWV)) begin
        vrw_wdata_reg <= bus.wdata;
      end
      if (wr_hit(`FA_OFS_W)) begin
        act_data_reg <= bus.wdata;
      end
      if (wr_hit(`FA_OFS_WV)) begin
        vw_wdata_reg <= bus.wdata;
      end
    end
  end

  // Writes to the read field are simply never decoded
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= `FA_RST_VAL;
    end else begin
      status_reg <= status_in;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rwh_reg <= `FA_RST_VAL;
    end else if (rwh_hw_load) begin
      rwh_reg <= rwh_hw_data;
    end else if (wr_hit(`FA_OFS_RWH)) begin
      rwh_reg <= bus.wdata;
    end
  end

  // ****************************************************************
  // Latch fields: set term is ORed last so a set beats a clear
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lhsc_reg <= '0;
      llsc_reg <= '0;
      lhmk_reg <= '0;
      llmk_reg <= '0;
    end else begin
      lhsc_reg <= (lhsc_reg & ~rd_mask(`FA_OFS_LHSC)) | lhsc_in;
      llsc_reg <= (llsc_reg & ~rd_mask(`FA_OFS_LLSC)) | ~llsc_in;
      lhmk_reg <= (lhmk_reg & ~wr_mask(`FA_OFS_LHMK)) | lhmk_in;
      llmk_reg <= (llmk_reg & ~wr_mask(`FA_OFS_LLMK)) | ~llmk_in;
    end
  end

  // ****************************************************************
  // Edge fields
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ihsc_prev_reg <= '0;
      ilsc_prev_reg <= '0;
      ihmk_prev_reg <= '0;
      ilmk_prev_reg <= '0;
    end else begin
      ihsc_prev_reg <= ihsc_in;
      ilsc_prev_reg <= ilsc_in;
      ihmk_prev_reg <= ihmk_in;
      ilmk_prev_reg <= ilmk_in;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ihsc_reg <= '0;
      ilsc_reg <= '0;
      ihmk_reg <= '0;
      ilmk_reg <= '0;
    end else begin
      ihsc_reg <= (ihsc_reg & ~rd_mask(`FA_OFS_IHSC)) | (ihsc_in & ~ihsc_prev_reg);
      ilsc_reg <= (ilsc_reg & ~rd_mask(`FA_OFS_ILSC)) | (~ilsc_in & ilsc_prev_reg);
      ihmk_reg <= (ihmk_reg & ~wr_mask(`FA_OFS_IHMK)) | (~ihmk_in & ihmk_prev_reg);
      ilmk_reg <= (ilmk_reg & ~wr_mask(`FA_OFS_ILMK)) | (ilmk_in & ~ilmk_prev_reg);
    end
  end

  // ****************************************************************
  // Interrupt enable
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ien_reg <= `FA_RST_VAL;
      irq_reg <= 1'b0;
    end else begin
      if (wr_hit(`FA_OFS_IEN)) begin
        ien_reg <= bus.wdata;
      end
      irq_reg <= |(ien_reg & (ihsc_reg | ilsc_reg | ihmk_reg | ilmk_reg));
    end
  end

  // ****************************************************************
  // Latch on reset and self-clearing fields
  // ****************************************************************
  // Reset loads constants only; the strap is sampled by the first edge after release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lor_reg      <= `FA_RST_VAL;
      lor_done_reg <= 1'b0;
    end else if (!lor_done_reg) begin
      lor_reg      <= lor_in;
      lor_done_reg <= 1'b1;
    end else if (wr_hit(`FA_OFS_LOR)) begin
      lor_reg <= bus.wdata;
    end
  end

  // A software write beats a hardware clear landing in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rwsc_reg        <= `FA_RST_VAL;
      rwsc_strobe_reg <= '0;
    end else begin
      rwsc_strobe_reg <= wr_mask(`FA_OFS_RWSC);
      if (wr_hit(`FA_OFS_RWSC)) begin
        rwsc_reg <= bus.wdata;
      end else begin
        rwsc_reg <= rwsc_reg & ~rwsc_clr;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    unique case (bus.addr)
      `FA_OFS_RW:   rd_mux = ctrl_reg;
      `FA_OFS_RWV:  rd_mux = vrw_rdata;
      `FA_OFS_R:    rd_mux = status_reg;
      `FA_OFS_RV:   rd_mux = vr_data;
      `FA_OFS_W:    rd_mux = `FA_W_READ_VAL;
      `FA_OFS_WV:   rd_mux = `FA_W_READ_VAL;
      `FA_OFS_RWH:  rd_mux = rwh_reg;
      `FA_OFS_LHSC: rd_mux = lhsc_reg;
      `FA_OFS_LLSC: rd_mux = llsc_reg;
      `FA_OFS_LHMK: rd_mux = lhmk_reg;
      `FA_OFS_LLMK: rd_mux = llmk_reg;
      `FA_OFS_IHSC: rd_mux = ihsc_reg;
      `FA_OFS_ILSC: rd_mux = ilsc_reg;
      `FA_OFS_IHMK: rd_mux = ihmk_reg;
      `FA_OFS_ILMK: rd_mux = ilmk_reg;
      `FA_OFS_IEN:  rd_mux = ien_reg;
      `FA_OFS_LOR:  rd_mux = lor_reg;
      `FA_OFS_RWSC: rd_mux = rwsc_reg;
      default:      rd_mux = `FA_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= bus.rd_en;
      if (bus.rd_en) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bus.rdata   = rdata_reg;
  assign bus.rvalid  = rvalid_reg;
  assign ctrl_out    = ctrl_reg;
  assign vrw_wr      = vrw_wr_reg;
  assign vrw_wdata   = vrw_wdata_reg;
  assign act_wr      = act_wr_reg;
  assign act_data    = act_data_reg;
  assign vw_wr       = vw_wr_reg;
  assign vw_wdata    = vw_wdata_reg;
  assign rwh_out     = rwh_reg;
  assign irq         = irq_reg;
  assign lor_out     = lor_reg;
  assign rwsc_strobe = rwsc_strobe_reg;
  assign rwsc_out    = rwsc_reg;

endmodule : field_access_regs

`default_nettype wire

// ==== design/field_access_defs.svh ====
// Register offsets, reset values and fixed read values of the field access library
`ifndef FIELD_ACCESS_DEFS_SVH
`define FIELD_ACCESS_DEFS_SVH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define FA_ADDR_W      5
`define FA_DATA_W      8

// ****************************************************************
// Field offsets
// ****************************************************************
`define FA_OFS_RW      5'h00
`define FA_OFS_RWV     5'h01
`define FA_OFS_R       5'h02
`define FA_OFS_RV      5'h03
`define FA_OFS_W       5'h04
`define FA_OFS_WV      5'h05
`define FA_OFS_RWH     5'h06
`define FA_OFS_LHSC    5'h07
`define FA_OFS_LLSC    5'h08
`define FA_OFS_LHMK    5'h09
`define FA_OFS_LLMK    5'h0a
`define FA_OFS_IHSC    5'h0b
`define FA_OFS_ILSC    5'h0c
`define FA_OFS_IHMK    5'h0d
`define FA_OFS_ILMK    5'h0e
`define FA_OFS_IEN     5'h0f
`define FA_OFS_LOR     5'h10
`define FA_OFS_RWSC    5'h11

// ****************************************************************
// Reset and constant values
// ****************************************************************
`define FA_RST_VAL     8'h00
`define FA_W_READ_VAL  8'h00
`define FA_UNMAPPED    8'h00

`endif

// ==== design/field_access_pkg.sv ====
// Types shared by both ends of the field access register bus
`default_nettype none

package field_access_pkg;

  // Host sequencer: Gray codes along idle -> issue -> wait
  typedef enum logic [1:0] {
    HOST_IDLE  = 2'b00,
    HOST_ISSUE = 2'b01,
    HOST_WAIT  = 2'b11
  } host_state_t;

endpackage : field_access_pkg

`default_nettype wire

// ==== design/reg_bus_if.sv ====
// Register bus joining the host end and the field access register file
`default_nettype none

interface reg_bus_if #(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 8
);
  logic              wr_en;
  logic              rd_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              rvalid;

  modport device (input wr_en, input rd_en, input addr, input wdata, output rdata, output rvalid);
  modport host   (output wr_en, output rd_en, output addr, output wdata, input rdata, input rvalid);
endinterface : reg_bus_if

`default_nettype wire

// ==== design/field_access_host.sv ====
// Host end: turns single commands into register bus cycles
`default_nettype none
`include "field_access_defs.svh"

module field_access_host
  import field_access_pkg::*;
#(
  parameter int ADDR_W = `FA_ADDR_W,
  parameter int DATA_W = `FA_DATA_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Register bus
  reg_bus_if.host                bus,
  // Command
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic                   cmd_ready,
  // Response
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_data
);

  host_state_t       state_reg;
  logic              ready_reg, rsp_valid_reg, wr_reg, rd_reg, is_wr_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg, rsp_data_reg;

  // ****************************************************************
  // Sequencer: one command in flight, strobes last one cycle
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= HOST_IDLE;
      ready_reg     <= 1'b1;
      wr_reg        <= 1'b0;
      rd_reg        <= 1'b0;
      is_wr_reg     <= 1'b0;
      rsp_valid_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= 1'b0;
      unique case (state_reg)
        HOST_IDLE: begin
          if (cmd_valid) begin
            wr_reg    <= cmd_write;
            rd_reg    <= !cmd_write;
            is_wr_reg <= cmd_write;
            ready_reg <= 1'b0;
            state_reg <= HOST_ISSUE;
          end
        end
        HOST_ISSUE: begin
          wr_reg <= 1'b0;
          rd_reg <= 1'b0;
          if (is_wr_reg) begin
            ready_reg <= 1'b1;
            state_reg <= HOST_IDLE;
          end else begin
            state_reg <= HOST_WAIT;
          end
        end
        HOST_WAIT: begin
          if (bus.rvalid) begin
            rsp_valid_reg <= 1'b1;
            ready_reg     <= 1'b1;
            state_reg     <= HOST_IDLE;
          end
        end
        default: begin
          ready_reg <= 1'b1;
          state_reg <= HOST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_reg     <= '0;
      wdata_reg    <= '0;
      rsp_data_reg <= '0;
    end else begin
      if (state_reg == HOST_IDLE && cmd_valid) begin
        addr_reg  <= cmd_addr;
        wdata_reg <= cmd_wdata;
      end
      if (state_reg == HOST_WAIT && bus.rvalid) begin
        rsp_data_reg <= bus.rdata;
      end
    end
  end

  assign bus.wr_en = wr_reg;
  assign bus.rd_en = rd_reg;
  assign bus.addr  = addr_reg;
  assign bus.wdata = wdata_reg;
  assign cmd_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data  = rsp_data_reg;

endmodule : field_access_host

`default_nettype wire

// ==== tb/field_access_props.sv ====
// Register bus checker for the field access library
`default_nettype none
`include "field_access_defs.svh"

module field_access_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Register bus
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Shadows of plain software fields
  // ****************************************************************
  logic [7:0] rw_reg;
  logic [7:0] ien_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rw_reg <= 8'h00;
    else if (wr_en && addr == `FA_OFS_RW) rw_reg <= wdata;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) ien_reg <= 8'h00;
    else if (wr_en && addr == `FA_OFS_IEN) ien_reg <= wdata;
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_rw_back;    rd_en && addr == `FA_OFS_RW |=> rdata == rw_reg; endproperty
  property p_ien_back;   rd_en && addr == `FA_OFS_IEN |=> rdata == ien_reg; endproperty
  property p_w_const;    rd_en && addr == `FA_OFS_W |=> rdata == `FA_W_READ_VAL; endproperty
  property p_wv_const;   rd_en && addr == `FA_OFS_WV |=> rdata == `FA_W_READ_VAL; endproperty
  property p_answer;     rd_en |=> rvalid; endproperty
  property p_no_stray;   rvalid |-> $past(rd_en); endproperty
  property p_rdata_hold; !rd_en |=> $stable(rdata); endproperty
  property p_rd_space;   rd_en |=> !rd_en [*2]; endproperty
  property p_wr_pulse;   wr_en |=> !wr_en && !rd_en; endproperty

  a_rw_back:    assert property (p_rw_back) else $error("rw field read mismatch");
  a_ien_back:   assert property (p_ien_back) else $error("enable field read mismatch");
  a_w_const:    assert property (p_w_const) else $error("write field read not constant");
  a_wv_const:   assert property (p_wv_const) else $error("virtual write read not constant");
  a_answer:     assert property (p_answer) else $error("read without answer");
  a_no_stray:   assert property (p_no_stray) else $error("answer without read");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  a_rd_space:   assert property (p_rd_space) else $error("reads too close");
  a_wr_pulse:   assert property (p_wr_pulse) else $error("write strobe too long");

  c_unmapped: cover property (rd_en && addr > `FA_OFS_RWSC);
  c_sc_write: cover property (wr_en && addr == `FA_OFS_RWSC);
  c_mask_clr: cover property (wr_en && addr == `FA_OFS_LHMK);
endmodule : field_access_props

`default_nettype wire

// ==== tb/register_field_access_types_tb.sv ====
// Testbench joining host end and register file across the register bus
`default_nettype none

module register_field_access_types_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, cmd_valid, cmd_write, cmd_ready, rsp_valid, rwh_hw_load;
  logic vrw_wr, act_wr, vw_wr, irq;
  logic [4:0] cmd_addr;
  logic [7:0] cmd_wdata, rsp_data, ctrl_out, vrw_rdata, vrw_wdata, status_in, vr_data, act_data;
  logic [7:0] vw_wdata, rwh_hw_data, rwh_out, lor_in, lor_out, rwsc_clr, rwsc_strobe, rwsc_out;
  logic [7:0] src [8];
  logic [7:0] idle [8] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] act_d, vw_d, vrw_d, rs_d;
  int fail_count, compares, act_n, vw_n, vrw_n, rs_n;

  reg_bus_if #(.ADDR_W(5), .DATA_W(8)) bus ();
  field_access_host i_field_access_host (.clk(clk), .sys_rst(sys_rst), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  field_access_regs i_field_access_regs (.clk(clk), .sys_rst(sys_rst), .bus(bus), .ctrl_out(ctrl_out),
    .vrw_rdata(vrw_rdata), .vrw_wr(vrw_wr), .vrw_wdata(vrw_wdata), .status_in(status_in), .vr_data(vr_data),
    .act_wr(act_wr), .act_data(act_data), .vw_wr(vw_wr), .vw_wdata(vw_wdata), .rwh_hw_load(rwh_hw_load),
    .rwh_hw_data(rwh_hw_data), .rwh_out(rwh_out), .lhsc_in(src[0]), .llsc_in(src[1]), .lhmk_in(src[2]),
    .llmk_in(src[3]), .ihsc_in(src[4]), .ilsc_in(src[5]), .ihmk_in(src[6]), .ilmk_in(src[7]), .irq(irq),
    .lor_in(lor_in), .lor_out(lor_out), .rwsc_clr(rwsc_clr), .rwsc_strobe(rwsc_strobe), .rwsc_out(rwsc_out));
  field_access_props i_field_access_props (.clk(clk), .sys_rst(sys_rst), .wr_en(bus.wr_en), .rd_en(bus.rd_en),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Count strobe cycles so a stretched pulse shows up as a count above one
  always @(posedge clk) begin
    if (act_wr === 1'b1) begin act_n++; act_d <= act_data; end
    if (vw_wr === 1'b1) begin vw_n++; vw_d <= vw_wdata; end
    if (vrw_wr === 1'b1) begin vrw_n++; vrw_d <= vrw_wdata; end
    if (rwsc_strobe !== 8'h00) begin rs_n++; rs_d <= rwsc_strobe; end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic close_out;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Issue one command at a falling edge once the host end is ready
  task automatic issue(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20) begin @(negedge clk); n++; end
    if (n == 20) begin fail_count++; close_out(); end
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : issue

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    issue(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    int n;
    issue(1'b0, a, 8'h00);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin @(negedge clk); n++; end
    if (n == 20) begin fail_count++; close_out(); end
    chk(rsp_data, exp);
  endtask : rdc

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    sys_rst = 1'b1; cmd_valid = 1'b0; cmd_write = 1'b0; cmd_addr = 5'h00; cmd_wdata = 8'h00;
    vrw_rdata = 8'h77; status_in = 8'h3c; vr_data = 8'h99; rwh_hw_load = 1'b0; rwh_hw_data = 8'h22;
    lor_in = 8'h5a; rwsc_clr = 8'h00;
    for (int i = 0; i < 8; i++) src[i] = idle[i];
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    lor_in = 8'h11;
    rdc(5'h10, 8'h5a);
    wr(5'h10, 8'h3c);
    rdc(5'h10, 8'h3c);
    chk(lor_out, 8'h3c);
    wr(5'h00, 8'ha5);
    rdc(5'h00, 8'ha5);
    chk(ctrl_out, 8'ha5);
    wr(5'h0f, 8'hff);
    rdc(5'h0f, 8'hff);
    wr(5'h0f, 8'h00);
    rdc(5'h01, 8'h77);
    wr(5'h01, 8'h12);
    wr(5'h02, 8'hff);
    rdc(5'h02, 8'h3c);
    chk(vrw_d, 8'h12);
    chk(8'(vrw_n), 8'h01);
    wr(5'h03, 8'h00);
    rdc(5'h03, 8'h99);
    wr(5'h04, 8'hc3);
    wr(5'h05, 8'he7);
    rdc(5'h04, 8'h00);
    rdc(5'h05, 8'h00);
    chk(act_d, 8'hc3);
    chk(8'(act_n), 8'h01);
    chk(vw_d, 8'he7);
    chk(8'(vw_n), 8'h01);
    wr(5'h06, 8'h11);
    rdc(5'h06, 8'h11);
    // Load lands on the edge that samples the write strobe: hardware must win
    wr(5'h06, 8'h33);
    rwh_hw_load = 1'b1;
    @(negedge clk);
    rwh_hw_load = 1'b0;
    rdc(5'h06, 8'h22);
    chk(rwh_out, 8'h22);
    // One-cycle pulse on bits 3:2; mask fields keep it across a read
    for (int i = 0; i < 8; i++) begin
      src[i] = idle[i] ^ 8'h0c;
      @(negedge clk);
      src[i] = idle[i];
      rdc(5'(7 + i), 8'h0c);
      rdc(5'(7 + i), i[1] ? 8'h0c : 8'h00);
      if (i[1]) begin
        wr(5'(7 + i), 8'h04);
        rdc(5'(7 + i), 8'h08);
      end
    end
    repeat (3) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    wr(5'h0f, 8'h08);
    repeat (3) @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    wr(5'h0f, 8'hf7);
    repeat (3) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    // Held level keeps setting while the read clears
    src[0] = 8'h01;
    rdc(5'h07, 8'h01);
    rdc(5'h07, 8'h01);
    src[0] = 8'h00;
    rdc(5'h07, 8'h01);
    rdc(5'h07, 8'h00);
    src[4] = 8'h0c;
    rdc(5'h0b, 8'h0c);
    rdc(5'h0b, 8'h00);
    src[4] = 8'h00;
    wr(5'h11, 8'h5a);
    rdc(5'h11, 8'h5a);
    chk(rs_d, 8'h5a);
    chk(8'(rs_n), 8'h01);
    rwsc_clr = 8'h0f;
    @(negedge clk);
    rwsc_clr = 8'h00;
    rdc(5'h11, 8'h50);
    chk(rwsc_out, 8'h50);
    wr(5'h1f, 8'hff);
    rdc(5'h1f, 8'h00);
    close_out();
  end
endmodule : register_field_access_types_tb

`default_nettype wire
